// file: rtl/ehsc_axis.v
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "ehsc_map.vh"
// Function
// - Count every one of the 500 encoder windows per revolution to track position.
// - Sample the once-per-revolution index as its own input, apart from phases.
// - Resolve motion from the quarter-period overlap of both phase detectors.
// - While homing, first index after home sensor covers becomes position zero.
// - Each index checks exactly 500 windows were counted since the previous index.
// - Drive the servo amplifier with pulse-width modulation, never a steady level.
// - In program mode compare position with goal, output speed and direction.
// - Accept move instructions and compute the goal position from them.
// - Pendant jog keys limit every joint to a very slow speed.
// - Ignore pendant keys other than home unless either pendant enable switch is held closed.
// - In teach mode block all motion while no enable switch is held.
// - Arm power button runs a test move; pass lights power, fail lights error.
// - Home button homes the axis; on success the home indicator stays lit.
// - Every 18 ms a watchdog tick scans for pending conditions and errors.
// - Report home sensor as 0 when exposed and 1 when covered.
// - An overrun removes drive from the servo motor at once.
module ehsc_axis #(
	parameter POS_W       = 32,
	parameter DUTY_W      = 10,
	parameter PPR         = `EHSC_PULSES_PER_REV,
	parameter TEST_CYCLES = `EHSC_TEST_CYCLES,
	parameter WDOG_CYCLES = `EHSC_WDOG_MS * `EHSC_CLK_KHZ
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        enc_index,
	input  wire        home_sensor,
	input  wire        overrun,
	input  wire        enable_left,
	input  wire        enable_right,
	input  wire        jog_fwd,
	input  wire        jog_rev,
	input  wire        power_btn,
	input  wire        home_btn,
	input  wire        halt_latched,
	output wire        servo_pwm,
	output wire        servo_dir,
	output reg         power_led,
	output reg         error_led,
	output reg         home_led
);
	localparam S_IDLE = 2'h0;
	localparam S_TEST = 2'h1;
	localparam S_DONE = 2'h2;
	localparam H_IDLE = 2'h0;
	localparam H_SEEK = 2'h1;
	localparam H_IDX  = 2'h2;
	localparam [31:0] WD_LAST = WDOG_CYCLES - 1;
	localparam [31:0] TC_LAST = TEST_CYCLES - 1;
	localparam [15:0] TEST_DUTY = `EHSC_TEST_DUTY;
	localparam [15:0] JOG_MAX   = `EHSC_JOG_DUTY_MAX;

	// ==========================================
	// Helper functions
	function [POS_W-1:0] f_abs;
		input [POS_W-1:0] v;
		begin
			f_abs = v[POS_W-1] ? (~v + 1'b1) : v;
		end
	endfunction

	function [31:0] f_strb;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer k;
		begin
			f_strb = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					f_strb[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================
	// Pin synchronisers
	reg [8:0] pin_s1;
	reg [8:0] pin_s2;
	reg       pwr_prev;
	reg       home_prev;
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1    <= 9'h000;
			pin_s2    <= 9'h000;
			pwr_prev  <= 1'b0;
			home_prev <= 1'b0;
		end else if (ce) begin
			pin_s1    <= {halt_latched, home_btn, power_btn, jog_rev, jog_fwd,
				enable_right, enable_left, overrun, home_sensor};
			pin_s2    <= pin_s1;
			pwr_prev  <= pin_s2[6];
			home_prev <= pin_s2[7];
		end
	end
	wire sens_covered = pin_s2[0];
	wire ovr          = pin_s2[1];
	wire enable_held  = pin_s2[2] | pin_s2[3];
	wire key_fwd      = pin_s2[4] & enable_held;
	wire key_rev      = pin_s2[5] & enable_held;
	wire pwr_press    = pin_s2[6] & ~pwr_prev & enable_held;
	wire home_press   = pin_s2[7] & ~home_prev;
	wire halt_set     = pin_s2[8];

	// ==========================================
	// Encoder decoder and drive stage
	wire step_up;
	wire step_dn;
	wire index_rise;
	reg  next_en;
	reg  [DUTY_W-1:0] next_duty;
	reg  next_dir;
	ehsc_quad u_quad (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.enc_a      (enc_a),
		.enc_b      (enc_b),
		.enc_index  (enc_index),
		.step_up    (step_up),
		.step_dn    (step_dn),
		.index_rise (index_rise)
	);
	ehsc_pwm #(
		.DUTY_W (DUTY_W)
	) u_pwm (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.drive_en (next_en),
		.duty     (next_duty),
		.dir_in   (next_dir),
		.pwm_out  (servo_pwm),
		.dir_out  (servo_dir)
	);

	// ==========================================
	// Registers
	reg [31:0]      ctrl;
	reg [POS_W-1:0] goal;
	reg [31:0]      speed;
	reg [POS_W-1:0] position;
	reg [POS_W-1:0] rev_cnt;
	reg [POS_W-1:0] rev_last;
	reg             idx_seen;
	reg             pos_err;
	reg             ovr_seen;
	reg [31:0]      scan_cnt;
	reg [31:0]      wd_cnt;
	reg [1:0]       chk_state;
	reg [31:0]      chk_cnt;
	reg [POS_W-1:0] chk_start;
	reg [1:0]       home_state;
	reg [7:0]       aw_addr;
	reg [31:0]      w_data;
	reg [3:0]       w_strb;
	reg             aw_have;
	reg             w_have;

	wire            do_write  = aw_have && w_have && !s_axi_bvalid;
	wire            wr_ctrl   = do_write && (aw_addr == `EHSC_REG_CTRL);
	wire            wr_flags  = do_write && (aw_addr == `EHSC_REG_FLAGS);
	wire [DUTY_W-1:0] max_duty = speed[DUTY_W-1:0];
	wire [DUTY_W-1:0] jog_duty = (speed[16 +: DUTY_W] > JOG_MAX) ?
		JOG_MAX[DUTY_W-1:0] : speed[16 +: DUTY_W];
	wire [POS_W-1:0] err_pos  = goal - position;
	wire [POS_W-1:0] err_mag  = f_abs(err_pos) << ctrl[`EHSC_CTRL_GAIN_LSB +: 4];
	wire [POS_W-1:0] step_pos = position + {{(POS_W-1){step_dn}}, step_up | step_dn};
	wire            index_ok = (f_abs(rev_cnt) == PPR);
	wire            teach_block = ctrl[`EHSC_CTRL_TEACH] & ~enable_held;
	wire            wd_tick = (wd_cnt == WD_LAST);

	// ==========================================
	// Drive selection
	always @* begin
		next_en   = 1'b0;
		next_duty = {DUTY_W{1'b0}};
		next_dir  = 1'b0;
		if (chk_state == S_TEST) begin
			next_en   = 1'b1;
			next_duty = TEST_DUTY[DUTY_W-1:0];
		end else if (home_state == H_SEEK || home_state == H_IDX) begin
			next_en   = 1'b1;
			next_duty = jog_duty;
		end else if ((key_fwd ^ key_rev) && !ctrl[`EHSC_CTRL_PROG_MODE]) begin
			next_en   = power_led;
			next_duty = jog_duty;
			next_dir  = key_rev;
		end else if (ctrl[`EHSC_CTRL_PROG_MODE] && ctrl[`EHSC_CTRL_SERVO_EN]) begin
			next_en   = power_led;
			next_duty = (err_mag > max_duty) ? max_duty : err_mag[DUTY_W-1:0];
			next_dir  = err_pos[POS_W-1];
		end
		if (ovr || teach_block) begin
			next_en = 1'b0;
		end
	end

	// ==========================================
	// Position, revolution check and homing
	always @(posedge aclk) begin
		if (!aresetn) begin
			position   <= {POS_W{1'b0}};
			rev_cnt    <= {POS_W{1'b0}};
			rev_last   <= {POS_W{1'b0}};
			idx_seen   <= 1'b0;
			pos_err    <= 1'b0;
			home_state <= H_IDLE;
			home_led   <= 1'b0;
		end else if (ce) begin
			position <= step_pos;
			rev_cnt  <= rev_cnt + {{(POS_W-1){step_dn}}, step_up | step_dn};
			if (wr_flags && w_strb[0] && w_data[`EHSC_FLAG_POS_ERR]) begin
				pos_err <= 1'b0;
			end
			if (index_rise) begin
				idx_seen <= 1'b1;
				rev_last <= rev_cnt;
				rev_cnt  <= {{(POS_W-1){step_dn}}, step_up | step_dn};
				if (idx_seen && ctrl[`EHSC_CTRL_REV_CHECK] && !index_ok) begin
					pos_err <= 1'b1;
				end
			end
			case (home_state)
				H_IDLE: begin
					if (home_press && power_led) begin
						home_led   <= 1'b0;
						home_state <= H_SEEK;
					end
				end
				H_SEEK: begin
					if (sens_covered) begin
						home_state <= H_IDX;
					end
				end
				H_IDX: begin
					if (index_rise) begin
						position   <= {POS_W{1'b0}};
						home_led   <= 1'b1;
						home_state <= H_IDLE;
					end
				end
				default: begin
					home_state <= H_IDLE;
				end
			endcase
			if ((home_state != H_IDLE) && (ovr || !power_led)) begin
				home_state <= H_IDLE;
			end
		end
	end

	// ==========================================
	// Power-up self check and watchdog scan
	always @(posedge aclk) begin
		if (!aresetn) begin
			chk_state <= S_IDLE;
			chk_cnt   <= 32'h0000_0000;
			chk_start <= {POS_W{1'b0}};
			power_led <= 1'b0;
			error_led <= 1'b0;
			ovr_seen  <= 1'b0;
			wd_cnt    <= 32'h0000_0000;
			scan_cnt  <= 32'h0000_0000;
		end else if (ce) begin
			if (wr_flags && w_strb[0] && w_data[`EHSC_FLAG_OVERRUN]) begin
				ovr_seen <= 1'b0;
			end
			if (ovr) begin
				ovr_seen <= 1'b1;
			end
			wd_cnt <= wd_tick ? 32'h0000_0000 : wd_cnt + 32'h0000_0001;
			if (wd_tick) begin
				scan_cnt <= scan_cnt + 32'h0000_0001;
				if (pos_err || ovr_seen) begin
					error_led <= 1'b1;
				end
			end
			case (chk_state)
				S_IDLE: begin
					if (pwr_press && !halt_set && !ovr) begin
						power_led <= 1'b0;
						error_led <= 1'b0;
						chk_cnt   <= 32'h0000_0000;
						chk_start <= position;
						chk_state <= S_TEST;
					end
				end
				S_TEST: begin
					chk_cnt <= chk_cnt + 32'h0000_0001;
					if (ovr || halt_set) begin
						error_led <= 1'b1;
						chk_state <= S_IDLE;
					end else if (chk_cnt == TC_LAST) begin
						chk_state <= S_DONE;
					end
				end
				S_DONE: begin
					if (f_abs(position - chk_start) >= `EHSC_TEST_MIN_STEPS) begin
						power_led <= 1'b1;
					end else begin
						error_led <= 1'b1;
					end
					chk_state <= S_IDLE;
				end
				default: begin
					chk_state <= S_IDLE;
				end
			endcase
			if (halt_set && chk_state != S_TEST) begin
				power_led <= 1'b0;
			end
		end
	end

	// ==========================================
	// AXI4-Lite write channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EHSC_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			ctrl          <= `EHSC_CTRL_RESET;
			goal          <= {POS_W{1'b0}};
			speed         <= `EHSC_SPEED_RESET;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_have       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_have       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `EHSC_RESP_OKAY;
				case (aw_addr)
					`EHSC_REG_CTRL:   ctrl  <= f_strb(ctrl, w_data, w_strb);
					`EHSC_REG_GOAL:   goal  <= f_strb(goal, w_data, w_strb);
					`EHSC_REG_MOVE:   goal  <= goal + w_data;
					`EHSC_REG_SPEED:  speed <= f_strb(speed, w_data, w_strb);
					`EHSC_REG_FLAGS:  s_axi_bresp <= `EHSC_RESP_OKAY;
					default:          s_axi_bresp <= `EHSC_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_have       <= 1'b0;
				w_have        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ==========================================
	// AXI4-Lite read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `EHSC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `EHSC_RESP_OKAY;
				case (s_axi_araddr)
					`EHSC_REG_CTRL:      s_axi_rdata <= ctrl;
					`EHSC_REG_GOAL:      s_axi_rdata <= goal;
					`EHSC_REG_MOVE:      s_axi_rdata <= goal;
					`EHSC_REG_STATUS:    s_axi_rdata <= {23'h000000, home_state != H_IDLE,
						chk_state != S_IDLE, enable_held, pos_err, ovr, error_led,
						power_led, home_led, sens_covered};
					`EHSC_REG_FLAGS:     s_axi_rdata <= {30'h00000000, ovr_seen, pos_err};
					`EHSC_REG_POSITION:  s_axi_rdata <= position;
					`EHSC_REG_REV_COUNT: s_axi_rdata <= rev_last;
					`EHSC_REG_SPEED:     s_axi_rdata <= speed;
					`EHSC_REG_SCAN:      s_axi_rdata <= scan_cnt;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `EHSC_RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// file: rtl/ehsc_map.vh
`ifndef EHSC_MAP_VH
`define EHSC_MAP_VH
// ==========================================
// Register offsets
`define EHSC_REG_CTRL      8'h00
`define EHSC_REG_GOAL      8'h04
`define EHSC_REG_MOVE      8'h08
`define EHSC_REG_STATUS    8'h0C
`define EHSC_REG_FLAGS     8'h10
`define EHSC_REG_POSITION  8'h14
`define EHSC_REG_REV_COUNT 8'h18
`define EHSC_REG_SPEED     8'h1C
`define EHSC_REG_SCAN      8'h20
// ==========================================
// Control fields
`define EHSC_CTRL_SERVO_EN  0
`define EHSC_CTRL_PROG_MODE 1
`define EHSC_CTRL_TEACH     2
`define EHSC_CTRL_REV_CHECK 3
`define EHSC_CTRL_GAIN_LSB  8
`define EHSC_CTRL_RESET     32'h0000_0008
`define EHSC_SPEED_RESET    32'h0010_0200
// ==========================================
// Flag fields (write one to clear)
`define EHSC_FLAG_POS_ERR 0
`define EHSC_FLAG_OVERRUN 1
// ==========================================
// Encoder, drive and timing
`define EHSC_PULSES_PER_REV 500
`define EHSC_JOG_DUTY_MAX   16'h0020
`define EHSC_TEST_DUTY      16'h0040
`define EHSC_TEST_MIN_STEPS 4
`define EHSC_TEST_CYCLES    2000
`define EHSC_WDOG_MS        18
`define EHSC_CLK_KHZ        250000
`define EHSC_RESP_OKAY      2'h0
`define EHSC_RESP_SLVERR    2'h2
`endif

// file: rtl/ehsc_quad.v
`timescale 1ns/100ps
module ehsc_quad (
	input  wire aclk,
	input  wire aresetn,
	input  wire ce,
	input  wire enc_a,
	input  wire enc_b,
	input  wire enc_index,
	output reg  step_up,
	output reg  step_dn,
	output reg  index_rise
);
	reg [1:0] a_sync;
	reg [1:0] b_sync;
	reg [1:0] i_sync;
	reg [1:0] ab_prev;
	reg       i_prev;
	wire [1:0] ab_now = {a_sync[1], b_sync[1]};
	// ==========================================
	// Synchronise and decode
	always @(posedge aclk) begin
		if (!aresetn) begin
			a_sync     <= 2'h0;
			b_sync     <= 2'h0;
			i_sync     <= 2'h0;
			ab_prev    <= 2'h0;
			i_prev     <= 1'b0;
			step_up    <= 1'b0;
			step_dn    <= 1'b0;
			index_rise <= 1'b0;
		end else if (ce) begin
			a_sync     <= {a_sync[0], enc_a};
			b_sync     <= {b_sync[0], enc_b};
			i_sync     <= {i_sync[0], enc_index};
			ab_prev    <= ab_now;
			i_prev     <= i_sync[1];
			// Entering the overlap with phase A leading counts up
			step_up    <= (ab_prev == 2'h2) && (ab_now == 2'h3);
			// Leaving the overlap back to A alone counts down
			step_dn    <= (ab_prev == 2'h3) && (ab_now == 2'h2);
			index_rise <= i_sync[1] && !i_prev;
		end
	end
endmodule

// file: rtl/ehsc_pwm.v
`timescale 1ns/100ps
module ehsc_pwm #(
	parameter DUTY_W = 10
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              ce,
	input  wire              drive_en,
	input  wire [DUTY_W-1:0] duty,
	input  wire              dir_in,
	output reg               pwm_out,
	output reg               dir_out
);
	reg [DUTY_W-1:0] cnt;
	// ==========================================
	// Free running period counter and compare
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt     <= {DUTY_W{1'b0}};
			pwm_out <= 1'b0;
			dir_out <= 1'b0;
		end else if (ce) begin
			cnt     <= cnt + 1'b1;
			pwm_out <= drive_en && (cnt < duty);
			dir_out <= dir_in;
		end
	end
endmodule

// file: tb/ehsc_axis_chk.sv
`timescale 1ns/100ps
module ehsc_axis_chk #(
	parameter DUTY_W = 10
) (
	input wire       aclk,
	input wire       aresetn,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire [1:0] s_axi_bresp,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire       enc_index,
	input wire       home_sensor,
	input wire       overrun,
	input wire       halt_latched,
	input wire       servo_pwm,
	input wire       power_led,
	input wire       error_led,
	input wire       home_led
);
	// ==========
	// Length of the current high phase of the drive
	int hi_run;
	always @(posedge aclk) begin
		if (!aresetn || !servo_pwm)
			hi_run <= 0;
		else
			hi_run <= hi_run + 1;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========
	// Properties
	chk_pwm_pulsed: assert property (hi_run < (1 << DUTY_W))
		else $error("drive high for a full period");
	chk_overrun_off: assert property (overrun [*6] |-> !servo_pwm)
		else $error("drive not removed on overrun");
	chk_halt_clears: assert property (halt_latched [*6] |-> !power_led)
		else $error("power lamp lit while halt latched");
	chk_home_covered: assert property ($rose(home_led) |-> $past(home_sensor, 2))
		else $error("homed without sensor covered");
	chk_home_index: assert property ($rose(home_led) |-> $past(enc_index, 2))
		else $error("homed without index pulse");
	chk_home_power: assert property ($rose(home_led) |-> power_led)
		else $error("homed without arm power");
	chk_test_power: assert property ($rose(power_led) |-> !error_led)
		else $error("power and error lamps both lit");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	cover property ($rose(power_led));
	cover property ($rose(error_led));
	cover property ($rose(home_led));
endmodule
bind ehsc_axis ehsc_axis_chk #(.DUTY_W(DUTY_W)) i_ehsc_axis_chk (.*);

// file: tb/ehsc_enc_model.sv
`timescale 1ns/100ps
module ehsc_enc_model #(
	parameter HOLD = 4
) (
	input  wire        aclk,
	input  wire        run,
	input  wire        dir,
	input  wire        follow,
	input  wire        servo_pwm,
	input  wire        servo_dir,
	input  wire [9:0]  ppr,
	output wire        enc_a,
	output wire        enc_b,
	output wire        enc_index,
	output reg  [31:0] pos,
	output reg  [9:0]  wcnt
);
	reg [1:0] ph;
	int       tmr;
	wire      rev = run ? dir : servo_dir;
	initial begin
		ph = 2'h0;
		tmr = 0;
		pos = 32'h0;
		wcnt = 10'h0;
	end
	// ==========
	// Both phases high only in one state of four
	assign enc_a = ph[0] ^ ph[1];
	assign enc_b = ph[1];
	assign enc_index = wcnt == 10'h0 && ph == 2'h3;
	// ==========
	// Free run, or follow the amplifier drive
	always @(posedge aclk) begin
		if (tmr > 0)
			tmr <= tmr - 1;
		else if (run || (follow && servo_pwm)) begin
			tmr <= HOLD - 1;
			ph <= rev ? ph - 2'h1 : ph + 2'h1;
			if (!rev && ph == 2'h1) begin
				pos <= pos + 32'h1;
				wcnt <= wcnt == ppr - 10'h1 ? 10'h0 : wcnt + 10'h1;
			end
			if (rev && ph == 2'h2) begin
				pos <= pos - 32'h1;
				wcnt <= wcnt == 10'h0 ? ppr - 10'h1 : wcnt - 10'h1;
			end
		end
	end
endmodule

// file: tb/encoder_homing_servo_control_test.sv
`timescale 1ns/100ps
`include "ehsc_map.vh"
module encoder_homing_servo_control_test;
	localparam int    TC = 3000;
	localparam int    WD = 100;
	localparam [31:0] ALL = 32'hFFFF_FFFF;
	logic        aclk;
	logic        aresetn = 1'h0;
	logic        ce = 1'h1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'h0;
	wire         s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'h0;
	wire         s_axi_wready;
	wire  [1:0]  s_axi_bresp;
	wire         s_axi_bvalid;
	logic        s_axi_bready = 1'h0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'h0;
	wire         s_axi_arready;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_rresp;
	wire         s_axi_rvalid;
	logic        s_axi_rready = 1'h0;
	wire         enc_a, enc_b, enc_index, servo_pwm, servo_dir, power_led, error_led, home_led;
	logic        home_sensor = 1'h0, overrun = 1'h0, enable_left = 1'h0, enable_right = 1'h0;
	logic        jog_fwd = 1'h0, jog_rev = 1'h0, power_btn = 1'h0, home_btn = 1'h0, halt_latched = 1'h0;
	logic        run = 1'h0, dir = 1'h0, follow = 1'h0;
	logic [9:0]  ppr = 10'h1F4;
	wire  [31:0] pos;
	wire  [9:0]  wcnt;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	ehsc_axis #(
		.TEST_CYCLES(TC),
		.WDOG_CYCLES(WD)
	) i_ehsc_axis (.*);
	ehsc_enc_model i_ehsc_enc_model (.*);
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end
	// ==========
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic rst;
		@(posedge aclk);
		aresetn <= 1'h0;
		cyc(4);
		aresetn <= 1'h1;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(n, d & m, e);
	endtask
	task automatic mv(input int n, input logic d);
		logic [31:0] t;
		t = d ? pos - n : pos + n;
		dir <= d;
		run <= 1'h1;
		while (pos != t)
			@(posedge aclk);
		run <= 1'h0;
		cyc(8);
	endtask
	task automatic pb;
		@(posedge aclk);
		power_btn <= 1'h1;
		cyc(8);
		power_btn <= 1'h0;
		cyc(TC + 200);
	endtask
	task automatic hi(output logic [31:0] h);
		cyc(1100);
		h = 0;
		repeat (1024) begin
			@(posedge aclk);
			h += servo_pwm;
		end
	endtask
	task automatic done_t(input string n);
		$display("%s done: %0d checks, %0d mismatches", n, checked, n_errors);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ==========
	// Sequence
	initial begin
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
		logic [31:0] h;
		logic [31:0] p;
		rst();
		rc(`EHSC_REG_CTRL, `EHSC_CTRL_RESET, "ctrl", ALL);
		rc(`EHSC_REG_SPEED, `EHSC_SPEED_RESET, "speed", ALL);
		rc(`EHSC_REG_GOAL, 32'h0, "goal", ALL);
		rd(8'h24, d, r);
		chk("rresp", r, `EHSC_RESP_SLVERR);
		chk("rdata", d, 32'h0);
		wr(`EHSC_REG_STATUS, 32'h1, r);
		chk("bresp ro", r, `EHSC_RESP_SLVERR);
		home_sensor <= 1'h1;
		cyc(8);
		rc(`EHSC_REG_STATUS, 32'h1, "sensor", 32'h1);
		home_sensor <= 1'h0;
		cyc(8);
		rc(`EHSC_REG_STATUS, 32'h0, "sensor", 32'h1);
		done_t("registers");
		mv(1001, 1'h0);
		rc(`EHSC_REG_POSITION, 32'h3E9, "position", ALL);
		rc(`EHSC_REG_REV_COUNT, 32'h1F4, "rev", ALL);
		rc(`EHSC_REG_FLAGS, 32'h0, "flags", 32'h1);
		ppr <= 10'h1F3;
		mv(499, 1'h0);
		rc(`EHSC_REG_REV_COUNT, 32'h1F3, "rev", ALL);
		rc(`EHSC_REG_FLAGS, 32'h1, "flags", 32'h1);
		wr(`EHSC_REG_FLAGS, 32'h1, r);
		chk("bresp", r, `EHSC_RESP_OKAY);
		rc(`EHSC_REG_FLAGS, 32'h0, "flags", 32'h1);
		mv(10, 1'h1);
		rc(`EHSC_REG_POSITION, 32'h5D2, "position", ALL);
		ppr <= 10'h1F4;
		done_t("encoder");
		rst();
		pb();
		chk("power", power_led, 1'h0);
		chk("error", error_led, 1'h0);
		enable_left <= 1'h1;
		halt_latched <= 1'h1;
		pb();
		chk("power", power_led, 1'h0);
		chk("error", error_led, 1'h0);
		halt_latched <= 1'h0;
		pb();
		chk("error", error_led, 1'h1);
		rst();
		follow <= 1'h1;
		pb();
		chk("power", power_led, 1'h1);
		chk("error", error_led, 1'h0);
		halt_latched <= 1'h1;
		cyc(8);
		chk("power", power_led, 1'h0);
		halt_latched <= 1'h0;
		pb();
		chk("power", power_led, 1'h1);
		follow <= 1'h0;
		done_t("power");
		wr(`EHSC_REG_SPEED, 32'h03FF_0200, r);
		jog_fwd <= 1'h1;
		hi(h);
		chk("jog duty", h, 32'h20);
		enable_left <= 1'h0;
		hi(h);
		chk("jog duty", h, 32'h0);
		jog_fwd <= 1'h0;
		jog_rev <= 1'h1;
		enable_left <= 1'h1;
		hi(h);
		chk("jog duty", h, 32'h20);
		chk("jog dir", servo_dir, 1'h1);
		jog_rev <= 1'h0;
		done_t("jog");
		home_btn <= 1'h1;
		cyc(8);
		home_btn <= 1'h0;
		dir <= 1'h0;
		run <= 1'h1;
		cyc(8100);
		chk("home", home_led, 1'h0);
		home_sensor <= 1'h1;
		while (!home_led)
			@(posedge aclk);
		run <= 1'h0;
		cyc(8);
		rc(`EHSC_REG_POSITION, wcnt, "home pos", ALL);
		chk("home", home_led, 1'h1);
		home_sensor <= 1'h0;
		done_t("homing");
		p = wcnt;
		wr(`EHSC_REG_CTRL, 32'hB, r);
		wr(`EHSC_REG_GOAL, p + 32'h3E8, r);
		hi(h);
		chk("prog duty", h, 32'h200);
		chk("dir", servo_dir, 1'h0);
		wr(`EHSC_REG_MOVE, 32'hFFFF_F830, r);
		rc(`EHSC_REG_GOAL, p - 32'h3E8, "goal", ALL);
		enable_left <= 1'h0;
		wr(`EHSC_REG_CTRL, 32'hF, r);
		hi(h);
		chk("teach duty", h, 32'h0);
		enable_right <= 1'h1;
		hi(h);
		chk("teach duty", h, 32'h200);
		chk("dir", servo_dir, 1'h1);
		overrun <= 1'h1;
		hi(h);
		chk("overrun duty", h, 32'h0);
		rc(`EHSC_REG_FLAGS, 32'h2, "flags", 32'h3);
		done_t("drive");
		rd(`EHSC_REG_SCAN, d, r);
		cyc(1000);
		rd(`EHSC_REG_SCAN, e, r);
		chk("scan", (e - d == 32'hA) || (e - d == 32'hB), 1'h1);
		chk("error", error_led, 1'h1);
		done_t("watchdog");
		wrap_up();
	end
endmodule
